/* File: rtl/cmo_pkg.sv */
// Purpose: shared constants and types of the comparator and amplifier control block
// Assumes: 32-bit Avalon-MM data, 24-bit byte addresses
// Notes:   every register takes one aligned word, data in the low bits
package cmo_pkg;

  localparam int ADDR_W = 24;
  localparam int DATA_W = 32;
  localparam int BE_W   = 4;
  localparam int CTRL_W = 8;
  localparam int STAT_W = 2;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] OFS_CTRL = 24'hff_e510;
  localparam logic [ADDR_W-1:0] OFS_STAT = 24'hff_e514;
  localparam logic [ADDR_W-1:0] OFS_MASK = 24'hff_e518;

  // Control register fields
  localparam int BIT_CMP_EN    = 0;
  localparam int BIT_CMP_OUT   = 1;
  localparam int BIT_FAULT_POL = 2;
  localparam int BIT_EDGE_SEL  = 3;
  localparam int BIT_NEG_SEL   = 4;
  localparam int BIT_AMP_EN    = 7;

  // Writable control bits; reserved bits read as zero, the live output bit is not stored and reads the comparator
  localparam logic [CTRL_W-1:0] CTRL_WMASK = 8'h9d;
  localparam logic [CTRL_W-1:0] CTRL_RST   = 8'h00;

  // Status and mask layout
  localparam int EV_CMP = 0;
  localparam int EV_AMP = 1;
  localparam logic [STAT_W-1:0] STAT_RST = 2'h0;
  localparam logic [STAT_W-1:0] MASK_RST = 2'h0;

  localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

  typedef enum logic {
    CMO_IDLE,
    CMO_ACK
  } cmo_bus_st_e;

  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic              read;
    logic              write;
    logic [DATA_W-1:0] writedata;
    logic [BE_W-1:0]   byteenable;
  } cmo_avs_req_s;

  typedef struct packed {
    logic [DATA_W-1:0] readdata;
    logic              waitrequest;
  } cmo_avs_rsp_s;

endpackage

/* File: rtl/cmo_sync.sv */
// Purpose: two-flop synchroniser for asynchronous levels
// Assumes: i_rstn already safe for this clock, or the reset being released
// Notes:   stage one is read by stage two only
`timescale 1ns/1ns
module cmo_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clk,
  input  wire logic             i_rstn,
  input  wire logic [WIDTH-1:0] i_d,
  output logic      [WIDTH-1:0] o_q
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } cmo_sync_s;

  cmo_sync_s r_reg;
  cmo_sync_s r_next;

  always_comb begin
    r_next    = r_reg;
    r_next.s1 = i_d;
    r_next.s2 = r_reg.s1;
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_q = r_reg.s2;

endmodule

/* File: rtl/cmo_edge.sv */
// Purpose: single-edge detector with selectable direction
// Assumes: i_level is already in the i_clk domain
// Notes:   o_pulse is combinational; the caller registers it
`timescale 1ns/1ns
module cmo_edge (
  input  wire logic i_clk,
  input  wire logic i_rstn,
  input  wire logic i_level,
  input  wire logic i_fall_sel,
  output logic      o_pulse
);

  typedef struct packed {
    logic prev;
  } cmo_edge_s;

  cmo_edge_s r_reg;
  cmo_edge_s r_next;

  always_comb begin
    r_next      = r_reg;
    r_next.prev = i_level;
    if (i_fall_sel) begin
      o_pulse = r_reg.prev & ~i_level;
    end else begin
      o_pulse = ~r_reg.prev & i_level;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

endmodule

/* File: rtl/cmo_top.sv */
// Purpose: digital control and status around the comparator and amplifier
// Assumes: analog compare and amplifier levels arrive asynchronously
// Notes:   Avalon-MM slave that answers every request in two cycles
// How it works
// - Output high when plus exceeds minus
// - Comparator runs only while enable bit set
// - Amplifier enable bit; output floats when off
// - Select bit routes B6 or C0 minus
// - Edge select: rising when 0, falling 1
// - Edge select alone; no any-change interrupt
// - Polarity bit picks fault direction
// - Read-only bit shows live comparator output
// - Amplifier level readable through port three
// - Amplifier level raises port B3 interrupt
// - Amplifier output feeds ADC channel three
//
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/1ns
module cmo_top
  import cmo_pkg::*;
(
  input  wire logic          i_clk,
  input  wire logic          i_rstn,
  input  wire cmo_avs_req_s  i_bus,
  output cmo_avs_rsp_s       o_bus,
  input  wire logic          i_cmp_raw,
  input  wire logic          i_amp_raw,
  input  wire logic          i_p3_schmitt_en,
  input  wire logic          i_b3_irq_en,
  input  wire logic          i_b3_fall_sel,
  output logic               o_cmp_power_en,
  output logic               o_neg_sel_c0,
  output logic               o_cmp_irq,
  output logic               o_pwm_fault,
  output logic               o_amp_out_oe,
  output logic               o_p3_amp_level,
  output logic               o_b3_irq,
  output logic               o_adc_ch3_en,
  output logic               o_irq
);

  typedef struct packed {
    cmo_bus_st_e       st;
    logic              waitreq;
    logic [DATA_W-1:0] rdata;
    logic [CTRL_W-1:0] ctrl;
    logic              cmp_out;
    logic [STAT_W-1:0] stat;
    logic [STAT_W-1:0] mask;
    logic              irq;
    logic              cmp_irq;
    logic              fault;
    logic              cmp_pwr;
    logic              neg_sel;
    logic              amp_oe;
    logic              p3_level;
    logic              b3_irq;
    logic              adc_ch3;
  } cmo_top_s;

  cmo_top_s r_reg;
  cmo_top_s r_next;

  logic              rstn_sync;
  logic [1:0]        raw_sync;
  logic              cmp_sync;
  logic              amp_sync;
  logic              cmp_edge;
  logic              amp_edge;
  logic              amp_level;
  logic              req;
  logic              hit_ctrl;
  logic              hit_stat;
  logic              hit_mask;
  logic              wr_low;
  logic [CTRL_W-1:0] ctrl_view;
  logic [STAT_W-1:0] stat_clr;
  logic [STAT_W-1:0] stat_set;
  logic              cmp_en;
  logic              amp_en;

  // Reset is applied at once and released through two flops
  cmo_sync #(
    .WIDTH (1)
  ) u_rst_sync (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .i_d    (1'b1),
    .o_q    (rstn_sync)
  );

  cmo_sync #(
    .WIDTH (2)
  ) u_raw_sync (
    .i_clk  (i_clk),
    .i_rstn (rstn_sync),
    .i_d    ({i_amp_raw, i_cmp_raw}),
    .o_q    (raw_sync)
  );

  assign cmp_sync = raw_sync[0];
  assign amp_sync = raw_sync[1];

  // Edges of the registered, gated comparator output
  cmo_edge u_cmp_edge (
    .i_clk      (i_clk),
    .i_rstn     (rstn_sync),
    .i_level    (r_reg.cmp_out),
    .i_fall_sel (r_reg.ctrl[BIT_EDGE_SEL]),
    .o_pulse    (cmp_edge)
  );

  // Amplifier level as the port input stage would see it
  assign amp_level = r_reg.ctrl[BIT_AMP_EN] & amp_sync;

  cmo_edge u_amp_edge (
    .i_clk      (i_clk),
    .i_rstn     (rstn_sync),
    .i_level    (amp_level),
    .i_fall_sel (i_b3_fall_sel),
    .o_pulse    (amp_edge)
  );

  always_comb begin
    r_next    = r_reg;
    stat_clr  = '0;
    stat_set  = '0;
    cmp_en    = r_reg.ctrl[BIT_CMP_EN];
    amp_en    = r_reg.ctrl[BIT_AMP_EN];
    req       = i_bus.read | i_bus.write;
    hit_ctrl  = (i_bus.address == OFS_CTRL);
    hit_stat  = (i_bus.address == OFS_STAT);
    hit_mask  = (i_bus.address == OFS_MASK);
    wr_low    = i_bus.write & i_bus.byteenable[0];

    // Live output bit merged into the stored control byte
    ctrl_view              = r_reg.ctrl;
    ctrl_view[BIT_CMP_OUT] = r_reg.cmp_out;

    // Bus slave: request seen, answer next cycle, write at the handshake
    case (r_reg.st)
      CMO_IDLE: begin
        r_next.waitreq = 1'b1;
        if (req) begin
          r_next.st      = CMO_ACK;
          r_next.waitreq = 1'b0;
          r_next.rdata   = RDATA_RST;
          if (i_bus.read) begin
            if (hit_ctrl) begin
              r_next.rdata[CTRL_W-1:0] = ctrl_view;
            end else if (hit_stat) begin
              r_next.rdata[STAT_W-1:0] = r_reg.stat;
            end else if (hit_mask) begin
              r_next.rdata[STAT_W-1:0] = r_reg.mask;
            end
          end
        end
      end
      CMO_ACK: begin
        r_next.st      = CMO_IDLE;
        r_next.waitreq = 1'b1;
        if (wr_low && hit_ctrl) begin
          r_next.ctrl = i_bus.writedata[CTRL_W-1:0] & CTRL_WMASK;
        end
        if (wr_low && hit_mask) begin
          r_next.mask = i_bus.writedata[STAT_W-1:0];
        end
        // Only bits already returned are cleared, so later events survive
        if (i_bus.read && hit_stat) begin
          stat_clr = r_reg.rdata[STAT_W-1:0];
        end
      end
      default: begin
        r_next.st      = CMO_IDLE;
        r_next.waitreq = 1'b1;
      end
    endcase

    // Comparator result held low while disabled
    r_next.cmp_out = cmp_en & cmp_sync;

    // One edge direction only; turning the enable off never interrupts, turning it on with the output high can
    r_next.cmp_irq = cmp_edge & cmp_en;

    // Fault direction follows the polarity bit
    r_next.fault = cmp_en & (r_next.cmp_out ^ r_reg.ctrl[BIT_FAULT_POL]);

    r_next.cmp_pwr = cmp_en;
    r_next.neg_sel = r_reg.ctrl[BIT_NEG_SEL];

    // Pin floats whenever the amplifier is off
    r_next.amp_oe  = amp_en;
    r_next.adc_ch3 = amp_en;

    r_next.p3_level = amp_level & i_p3_schmitt_en;
    r_next.b3_irq   = amp_edge & i_b3_irq_en;

    stat_set[EV_CMP] = r_next.cmp_irq;
    stat_set[EV_AMP] = r_next.b3_irq;

    // A set in the clearing cycle wins
    r_next.stat = (r_reg.stat & ~stat_clr) | stat_set;
    r_next.irq  = |(r_next.stat & r_next.mask);
  end

  always_ff @(posedge i_clk or negedge rstn_sync) begin
    if (!rstn_sync) begin
      r_reg.st       <= CMO_IDLE;
      r_reg.waitreq  <= 1'b1;
      r_reg.rdata    <= RDATA_RST;
      r_reg.ctrl     <= CTRL_RST;
      r_reg.cmp_out  <= 1'b0;
      r_reg.stat     <= STAT_RST;
      r_reg.mask     <= MASK_RST;
      r_reg.irq      <= 1'b0;
      r_reg.cmp_irq  <= 1'b0;
      r_reg.fault    <= 1'b0;
      r_reg.cmp_pwr  <= 1'b0;
      r_reg.neg_sel  <= 1'b0;
      r_reg.amp_oe   <= 1'b0;
      r_reg.p3_level <= 1'b0;
      r_reg.b3_irq   <= 1'b0;
      r_reg.adc_ch3  <= 1'b0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_bus.readdata    = r_reg.rdata;
  assign o_bus.waitrequest = r_reg.waitreq;
  assign o_cmp_power_en    = r_reg.cmp_pwr;
  assign o_neg_sel_c0      = r_reg.neg_sel;
  assign o_cmp_irq         = r_reg.cmp_irq;
  assign o_pwm_fault       = r_reg.fault;
  assign o_amp_out_oe      = r_reg.amp_oe;
  assign o_p3_amp_level    = r_reg.p3_level;
  assign o_b3_irq          = r_reg.b3_irq;
  assign o_adc_ch3_en      = r_reg.adc_ch3;
  assign o_irq             = r_reg.irq;

endmodule

/* File: testbench/cmo_top_monitor.sv */
// Purpose: port checker for cmo_top
// Assumes: one clock, reset low at the top port
// Notes:   control writes seen by snooping the handshake
`timescale 1ns/1ns
module cmo_top_monitor
  import cmo_pkg::*;
(
  input wire logic         i_clk,
  input wire logic         i_rstn,
  input wire cmo_avs_req_s i_bus,
  input wire cmo_avs_rsp_s o_bus,
  input wire logic         i_b3_irq_en,
  input wire logic         o_cmp_power_en,
  input wire logic         o_neg_sel_c0,
  input wire logic         o_cmp_irq,
  input wire logic         o_pwm_fault,
  input wire logic         o_amp_out_oe,
  input wire logic         o_p3_amp_level,
  input wire logic         o_b3_irq,
  input wire logic         o_adc_ch3_en
);
  logic ctrl_wr;
  assign ctrl_wr = i_bus.write && !o_bus.waitrequest && i_bus.byteenable[0]
                   && i_bus.address == OFS_CTRL;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  sequence taken_s;
    $rose(i_bus.read || i_bus.write);
  endsequence
  sequence answer_s;
    o_bus.waitrequest ##1 !o_bus.waitrequest ##1 o_bus.waitrequest;
  endsequence
  bus_answer_a: assert property (taken_s |-> answer_s)
    else $error("bus answer out of step");
  // The write lands at the handshake edge and the pin follows one edge later
  cmp_en_a: assert property (ctrl_wr |-> ##2
    o_cmp_power_en == $past(i_bus.writedata[0], 2))
    else $error("enable not written");
  neg_sel_a: assert property (ctrl_wr |-> ##2
    o_neg_sel_c0 == $past(i_bus.writedata[4], 2))
    else $error("minus select not written");
  amp_en_a: assert property (ctrl_wr |-> ##2
    o_amp_out_oe == $past(i_bus.writedata[7], 2))
    else $error("amplifier enable not written");
  cmp_pulse_a: assert property (o_cmp_irq |=> !o_cmp_irq)
    else $error("request pulse too long");
  b3_pulse_a: assert property (o_b3_irq |-> $past(i_b3_irq_en) ##1 !o_b3_irq)
    else $error("port pulse wrong");
  amp_pins_a: assert property (o_amp_out_oe == o_adc_ch3_en)
    else $error("drive and adc path differ");
  fault_off_a: assert property (!o_cmp_power_en [*2] |-> !o_pwm_fault && !o_cmp_irq)
    else $error("comparator active while off");
  p3_gate_a: assert property (!o_amp_out_oe [*2] |-> !o_p3_amp_level)
    else $error("level seen while off");
endmodule
bind cmo_top cmo_top_monitor u_mon (.*);

/* File: testbench/cmo_analog_model.sv */
// Purpose: analog side of the comparator and amplifier
// Assumes: voltages as 8-bit codes
// Notes:   no propagation delay; the design syncs anyway
`timescale 1ns/1ns
module cmo_analog_model (
  input  wire logic [7:0] i_plus,
  input  wire logic [7:0] i_minus_b6,
  input  wire logic [7:0] i_minus_c0,
  input  wire logic       i_neg_sel_c0,
  input  wire logic [7:0] i_amp_plus,
  input  wire logic [7:0] i_amp_minus,
  output logic            o_cmp_raw,
  output logic            o_amp_raw
);
  logic [7:0] minus;
  assign minus = i_neg_sel_c0 ? i_minus_c0 : i_minus_b6;
  // Software has routed both input pins to the comparator before any test
  assign o_cmp_raw = i_plus > minus;
  // Open loop, so the amplifier acts as a second comparator
  assign o_amp_raw = i_amp_plus > i_amp_minus;
endmodule

/* File: testbench/tb_comparator_opamp_control.sv */
// Purpose: self-checking bench for cmo_top
// Assumes: analog model drives both raw levels
// Notes:   bus waits have no bound of their own; only the watchdog ends them
`timescale 1ns/1ns
module tb_comparator_opamp_control;
  import cmo_pkg::*;
  logic         clk = 1'b0;
  logic         rstn = 1'b0;
  cmo_avs_req_s bus = '0;
  cmo_avs_rsp_s rsp;
  logic [7:0]   plus = 8'h00, mb6 = 8'h80, mc0 = 8'h80, ap = 8'h00, am = 8'h80;
  logic         sch = 1'b0, b3en = 1'b0, b3fall = 1'b0;
  logic         craw, araw, pen, nsel, cirq, flt, oe, p3, birq, adc, irq;
  int           mismatches = 0, check_count = 0, cp = 0, bp = 0;
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cp <= cp + int'(cirq === 1'b1);
    bp <= bp + int'(birq === 1'b1);
  end
  cmo_analog_model u_ana (.i_plus(plus), .i_minus_b6(mb6), .i_minus_c0(mc0),
    .i_neg_sel_c0(nsel), .i_amp_plus(ap), .i_amp_minus(am), .o_cmp_raw(craw), .o_amp_raw(araw));
  cmo_top dut (.i_clk(clk), .i_rstn(rstn), .i_bus(bus), .o_bus(rsp), .i_cmp_raw(craw),
    .i_amp_raw(araw), .i_p3_schmitt_en(sch), .i_b3_irq_en(b3en), .i_b3_fall_sel(b3fall),
    .o_cmp_power_en(pen), .o_neg_sel_c0(nsel), .o_cmp_irq(cirq), .o_pwm_fault(flt),
    .o_amp_out_oe(oe), .o_p3_amp_level(p3), .o_b3_irq(birq), .o_adc_ch3_en(adc), .o_irq(irq));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic acc(input logic w, input logic [23:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    bus <= '{address: a, read: !w, write: w, writedata: d, byteenable: 4'hf};
    // No cycle count assumed; only the watchdog ends a wait that never gets its answer
    do begin
      @(posedge clk);
    end while (rsp.waitrequest !== 1'b0);
    q = rsp.readdata;
    bus.read <= 1'b0;
    bus.write <= 1'b0;
  endtask
  task automatic wr(input logic [23:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [23:0] a, input logic [31:0] e);
    logic [31:0] q;
    acc(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic t_reset_values;
    chk({pen, nsel, cirq, flt, oe, p3, birq, adc, irq}, 32'h0);
    rd(OFS_CTRL, 32'h0);
    rd(OFS_STAT, 32'h0);
    rd(OFS_MASK, 32'h0);
    rd(24'hff_e51c, 32'h0);
  endtask
  task automatic t_ctrl_fields;
    wr(OFS_CTRL, 32'hff);
    tick(4);
    chk({pen, nsel, oe, adc, flt}, 32'h1f);
    wr(24'hff_e51c, 32'h0);
    rd(OFS_CTRL, 32'h9d);
    wr(OFS_CTRL, 32'h0);
    tick(3);
    chk({pen, nsel, oe, adc, flt}, 32'h0);
  endtask
  task automatic t_cmp_edges;
    int c;
    wr(OFS_MASK, 32'h1);
    for (int s = 0; s < 2; s++) begin
      wr(OFS_CTRL, 32'(s * 8 + 1));
      c = cp;
      plus <= 8'h90;
      tick(8);
      chk(cp - c, 1 - s);
      chk(irq, 1 - s);
      rd(OFS_CTRL, 32'(s * 8 + 3));
      rd(OFS_STAT, 32'(1 - s));
      tick(2);
      chk(irq, 0);
      c = cp;
      plus <= 8'h10;
      tick(8);
      chk(cp - c, s);
      rd(OFS_STAT, 32'(s));
    end
  endtask
  task automatic t_neg_sel;
    int c;
    wr(OFS_CTRL, 32'h11);
    mc0 <= 8'hff;
    plus <= 8'h90;
    tick(6);
    rd(OFS_CTRL, 32'h11);
    chk(flt, 0);
    mc0 <= 8'h10;
    tick(6);
    rd(OFS_CTRL, 32'h13);
    chk(flt, 1);
    wr(OFS_CTRL, 32'h10);
    c = cp;
    plus <= 8'h00;
    tick(4);
    plus <= 8'h90;
    tick(8);
    chk(cp - c, 0);
    chk(flt, 0);
    rd(OFS_CTRL, 32'h10);
  endtask
  task automatic t_amp;
    int c;
    wr(OFS_MASK, 32'h2);
    tick(2);
    chk(irq, 0);
    b3en <= 1'b1;
    sch <= 1'b1;
    wr(OFS_CTRL, 32'h80);
    // Pin drive follows the stored bit one cycle after the write lands
    tick(2);
    chk({oe, adc}, 32'h3);
    c = bp;
    ap <= 8'hff;
    tick(8);
    chk(p3, 1);
    chk(bp - c, 1);
    chk(irq, 1);
    rd(OFS_STAT, 32'h3);
    ap <= 8'h00;
    tick(8);
    chk(bp - c, 1);
    chk(p3, 0);
    b3fall <= 1'b1;
    ap <= 8'hff;
    tick(8);
    chk(bp - c, 1);
    ap <= 8'h00;
    tick(8);
    chk(bp - c, 2);
    // Port interrupt and input stage both off: no pulse, no level
    b3en <= 1'b0;
    sch <= 1'b0;
    ap <= 8'hff;
    tick(8);
    chk(p3, 0);
    ap <= 8'h00;
    tick(8);
    chk(bp - c, 2);
    wr(OFS_CTRL, 32'h0);
    tick(3);
    chk({oe, adc, p3}, 32'h0);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    tick(4);
    t_reset_values();
    t_ctrl_fields();
    t_cmp_edges();
    t_neg_sel();
    t_amp();
    wrap_up();
  end
  // Whole run needs well under two thousand cycles
  initial begin
    #200000;
    mismatches++;
    wrap_up();
  end
endmodule
